/* dmahp_device.sv */
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Eight registers contiguous at switch-set base
// RULE_02: Host loads pointer, negated count, then go
// RULE_03: Data moves only after front-end request
// RULE_04: Inbound go clears ready, starts transfer
// RULE_05: Inbound clear bit resets inbound channel
// RULE_06: Inbound done flag, interrupt, clear on read
// RULE_07: Bits four, five extend DMA address
// RULE_08: Interrupt enable gates interrupt requests
// RULE_09: Ready while idle; config writes only then
// RULE_10: Writing ready during DMA stops it
// RULE_11: Inbound buffer flag, cleared on read
// RULE_12: Front-end halt state readable
// RULE_13: Four front-end status flags read-only
// RULE_14: Unanswered DMA address sets no-memory flag
// RULE_15: Error bit is OR of errors
// RULE_16: Outbound go clears ready, starts transfer
// RULE_17: Outbound clear bit resets outbound channel
// RULE_18: Outbound reserved bit never set, reads zero
// RULE_19: Outbound bit three restarts front-end processor
// RULE_20: Outbound buffer-empty flag only in DMA
// RULE_21: Four host flags to front end
// RULE_22: Word streams carry multiplexing messages untouched
// RULE_23: Default base and interrupt vectors
// RULE_24: Step pointer and count, finish at zero
module dmahp_device
  import dmahp_pkg::*;
#(
  parameter logic [17:0] BASE_ADDR = CSR_BASE
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  dmahp_if.dev bus,
  input wire logic fe_rx_req_in,
  input wire logic fe_rx_valid_in,
  input wire logic [15:0] fe_rx_data_in,
  output logic fe_rx_ready_out,
  input wire logic fe_tx_req_in,
  output logic fe_tx_valid_out,
  output logic [15:0] fe_tx_data_out,
  input wire logic fe_tx_ready_in,
  input wire logic frontend_cpu_halted_in,
  input wire logic [3:0] frontend_status_in,
  output logic [3:0] host_status_out,
  output logic frontend_cpu_restart_out
);
  // Index 0 is the inbound channel, index 1 the outbound one
  logic [1:0] rdy;
  logic [1:0] irqe;
  logic [1:0] nmr;
  logic [1:0] ext [2];
  logic [15:0] ptr [2];
  logic [15:0] cnt [2];
  logic rx_sig;
  logic rx_full;
  logic [15:0] rx_buf;
  dmahp_mb_t mb_state;
  logic mb_ch;
  logic take;
  logic wr;
  logic rd;
  logic [2:0] ix;
  logic [15:0] wd;
  logic [15:0] rval;
  logic rx_take;
  logic [1:0] csr_wr;
  logic [1:0] ptr_wr;
  logic [1:0] cnt_wr;
  logic [1:0] go;
  logic [1:0] clr;
  logic [1:0] stop;
  logic [1:0] busy;
  logic [1:0] ok;
  logic [1:0] err;
  logic [1:0] done;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  assign ix = bus.reg_addr[3:1];
  assign wd = bus.reg_wdata;
  // RULE_01: contiguous block decode
  // RULE_23: base from switch parameter
  assign take = bus.reg_sel & ~bus.reg_ack & (bus.reg_addr == dmahp_reg_addr(BASE_ADDR, ix));
  assign wr = take & bus.reg_we;
  assign rd = take & ~bus.reg_we;
  // RULE_11: take only while in DMA
  assign rx_take = fe_rx_valid_in & fe_rx_ready_out & ~rdy[0] & ~rx_full;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      csr_wr[c] = wr && ix == {c[0], OF_CSR};
      ptr_wr[c] = wr && ix == {c[0], OF_PTR} && rdy[c];
      cnt_wr[c] = wr && ix == {c[0], OF_CNT} && rdy[c];
      // RULE_04: go when idle
      // RULE_16: outbound go likewise
      go[c] = csr_wr[c] && wd[B_GO] && rdy[c];
      // RULE_05: channel clear strobe
      // RULE_17: outbound clear strobe
      clr[c] = csr_wr[c] && wd[B_CLR];
      // RULE_10: ready write stops DMA
      stop[c] = csr_wr[c] && wd[B_RDY] && !rdy[c];
      busy[c] = mb_state == MB_WAIT && mb_ch == c[0];
      ok[c] = busy[c] && bus.mem_ack && !rdy[c];
      err[c] = busy[c] && bus.mem_nmr;
    end
    // RULE_24: end of count finishes
    done[0] = !rdy[0] && cnt[0] == 16'h0000 && !rx_full && !busy[0];
    done[1] = !rdy[1] && cnt[1] == 16'h0000 && !fe_tx_valid_out && !busy[1];
  end

  // ------------------------------------------------------------
  // Channel control, pointer and count
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    for (int c = 0; c < 2; c++) begin
      if (rst_in || clr[c]) begin
        rdy[c] <= CSR_RESET[B_RDY];
        irqe[c] <= 1'b0;
        nmr[c] <= 1'b0;
        ext[c] <= 2'b00;
        ptr[c] <= 16'h0000;
        cnt[c] <= 16'h0000;
      end else begin
        // RULE_09: ready falls on go, rises when idle
        if (go[c]) begin
          rdy[c] <= 1'b0;
        end else if (stop[c] || done[c] || err[c]) begin
          rdy[c] <= 1'b1;
        end
        if (csr_wr[c] && rdy[c]) begin
          // RULE_08: enable written while idle
          irqe[c] <= wd[B_IRQE];
          // RULE_07: software-only address extension
          ext[c] <= wd[B_EXT+1:B_EXT];
        end
        // RULE_14: set wins over clear
        if (err[c]) begin
          nmr[c] <= 1'b1;
        end else if (csr_wr[c] && !wd[B_NMR]) begin
          nmr[c] <= 1'b0;
        end
        // RULE_24: step per word
        if (ptr_wr[c]) begin
          ptr[c] <= wd;
        end else if (ok[c]) begin
          ptr[c] <= ptr[c] + PTR_STEP;
        end
        if (cnt_wr[c]) begin
          cnt[c] <= wd;
        end else if (ok[c]) begin
          cnt[c] <= cnt[c] + CNT_STEP;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Inbound buffer and completion flag
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || clr[0]) begin
      rx_sig <= 1'b0;
    end else if (done[0]) begin
      // RULE_06: completion wins over read clear
      rx_sig <= 1'b1;
    end else if (rd && ix == IX_ICSR) begin
      rx_sig <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || clr[0]) begin
      rx_full <= 1'b0;
      rx_buf <= 16'h0000;
      fe_rx_ready_out <= 1'b0;
    end else begin
      // RULE_22: words pass unaltered
      if (rx_take) begin
        rx_buf <= fe_rx_data_in;
        rx_full <= 1'b1;
      end else if (ok[0] || (rd && ix == IX_IDR)) begin
        // RULE_11: cleared on store or read
        rx_full <= 1'b0;
      end
      // RULE_03: accept only on posted request
      fe_rx_ready_out <= !rdy[0] && fe_rx_req_in && !rx_full && !rx_take
                         && cnt[0] != 16'h0000 && !stop[0];
    end
  end

  // ------------------------------------------------------------
  // Outbound buffer, host flags, front-end restart
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || clr[1]) begin
      fe_tx_valid_out <= 1'b0;
      fe_tx_data_out <= 16'h0000;
      host_status_out <= 4'h0;
    end else begin
      // RULE_20: buffer written clears empty flag
      if (wr && ix == IX_ODR && !rdy[1]) begin
        fe_tx_data_out <= wd;
        fe_tx_valid_out <= 1'b1;
      end else if (ok[1]) begin
        fe_tx_data_out <= bus.mem_rdata;
        fe_tx_valid_out <= 1'b1;
      end else if (fe_tx_ready_in) begin
        fe_tx_valid_out <= 1'b0;
      end
      // RULE_21: host flags written while idle
      if (csr_wr[1] && rdy[1]) begin
        host_status_out <= wd[B_ST+3:B_ST];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      frontend_cpu_restart_out <= 1'b0;
    end else begin
      // RULE_19: one-cycle restart pulse
      frontend_cpu_restart_out <= csr_wr[1] && wd[B_FRST];
    end
  end

  // ------------------------------------------------------------
  // Host memory master, one word in flight at a time
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mb_state <= MB_IDLE;
      mb_ch <= 1'b0;
      bus.mem_req <= 1'b0;
      bus.mem_we <= 1'b0;
      bus.mem_addr <= 18'h00000;
      bus.mem_wdata <= 16'h0000;
    end else begin
      case (mb_state)
        MB_IDLE: begin
          // RULE_03: move only with front-end request
          if (!rdy[0] && fe_rx_req_in && rx_full && !clr[0] && !stop[0]) begin
            mb_state <= MB_WAIT;
            mb_ch <= 1'b0;
            bus.mem_req <= 1'b1;
            bus.mem_we <= 1'b1;
            // RULE_07: extension bits on top
            bus.mem_addr <= {ext[0], ptr[0]};
            bus.mem_wdata <= rx_buf;
          end else if (!rdy[1] && fe_tx_req_in && !fe_tx_valid_out
                       && cnt[1] != 16'h0000 && !clr[1] && !stop[1]) begin
            mb_state <= MB_WAIT;
            mb_ch <= 1'b1;
            bus.mem_req <= 1'b1;
            bus.mem_we <= 1'b0;
            bus.mem_addr <= {ext[1], ptr[1]};
          end
        end
        MB_WAIT: begin
          if (bus.mem_ack || bus.mem_nmr) begin
            mb_state <= MB_IDLE;
            bus.mem_req <= 1'b0;
          end
        end
        default: begin
          mb_state <= MB_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register read-back and interrupt lines
  // ------------------------------------------------------------
  always_comb begin
    case (ix)
      // RULE_12: halt state
      // RULE_13: front-end flags
      // RULE_15: error is OR of errors
      IX_ICSR: rval = {nmr[0], nmr[0], frontend_status_in, frontend_cpu_halted_in,
                       rx_full & ~rdy[0], rdy[0], irqe[0], ext[0], 1'b0, rx_sig, 2'b00};
      // RULE_18: reserved bit reads zero
      IX_OCSR: rval = {nmr[1], nmr[1], host_status_out, 1'b0,
                       ~rdy[1] & ~fe_tx_valid_out, rdy[1], irqe[1], ext[1], 4'h0};
      IX_IDR: rval = rx_buf;
      IX_IAR: rval = ptr[0];
      IX_ICNT: rval = cnt[0];
      IX_ODR: rval = fe_tx_data_out;
      IX_OAR: rval = ptr[1];
      IX_OCNT: rval = cnt[1];
      default: rval = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bus.reg_ack <= 1'b0;
      bus.reg_rdata <= 16'h0000;
      bus.irq <= 2'b00;
      bus.irq_vec <= VEC_IN;
    end else begin
      bus.reg_ack <= take;
      if (take) begin
        bus.reg_rdata <= rval;
      end
      // RULE_06: completion interrupt
      // RULE_08: only while enabled
      bus.irq[0] <= rx_sig & irqe[0];
      bus.irq[1] <= rdy[1] & irqe[1];
      // RULE_23: inbound vector has priority
      bus.irq_vec <= (rx_sig & irqe[0]) ? VEC_IN : VEC_OUT;
    end
  end
endmodule // dmahp_device

/* dmahp_host.sv */
`timescale 1ns/1ps
module dmahp_host
  import dmahp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  dmahp_if.host bus,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  logic access;
  logic commit;
  logic m_hit;
  logic mapped;
  logic launch;
  logic serve;
  logic d_hit;
  logic [17:0] base;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [2:0] cmd_idx;
  logic cmd_we;
  logic busy;
  logic tmo;
  logic [3:0] tmo_cnt;
  logic [15:0] m_rd;

  // ------------------------------------------------------------
  // APB slave, one wait state on every transfer
  // ------------------------------------------------------------
  assign access = psel_in & penable_in;
  assign commit = access & pready_out & pwrite_in;
  assign m_hit = paddr_in[11:8] == A_MEM[11:8];
  assign mapped = m_hit || paddr_in == A_CMD || paddr_in == A_WDATA
                  || paddr_in == A_RDATA || paddr_in == A_STAT || paddr_in == A_BASE;
  // RULE_02: software orders pointer, count, go
  assign launch = commit && paddr_in == A_CMD && pwdata_in[C_GO] && !busy;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= access & ~pready_out;
      pslverr_out <= access & ~pready_out & ~mapped;
      if (access && !pready_out) begin
        if (m_hit) begin
          prdata_out <= {16'h0000, m_rd};
        end else begin
          case (paddr_in)
            A_CMD: prdata_out <= {busy, 22'h000000, cmd_we, 5'h00, cmd_idx};
            A_WDATA: prdata_out <= {16'h0000, wdata};
            A_RDATA: prdata_out <= {16'h0000, rdata};
            A_STAT: prdata_out <= {16'h0000, bus.irq_vec, 4'h0, bus.irq, tmo, busy};
            A_BASE: prdata_out <= {14'h0000, base};
            default: prdata_out <= 32'h00000000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      base <= CSR_BASE;
      wdata <= 16'h0000;
    end else if (commit) begin
      if (paddr_in == A_BASE) begin
        base <= pwdata_in[17:0];
      end
      if (paddr_in == A_WDATA) begin
        wdata <= pwdata_in[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Device register access engine
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      tmo <= 1'b0;
      tmo_cnt <= 4'h0;
      cmd_idx <= 3'h0;
      cmd_we <= 1'b0;
      rdata <= 16'h0000;
      bus.reg_sel <= 1'b0;
      bus.reg_we <= 1'b0;
      bus.reg_addr <= 18'h00000;
      bus.reg_wdata <= 16'h0000;
    end else if (launch) begin
      busy <= 1'b1;
      tmo <= 1'b0;
      tmo_cnt <= 4'h0;
      cmd_idx <= pwdata_in[2:0];
      cmd_we <= pwdata_in[C_WR];
      bus.reg_sel <= 1'b1;
      bus.reg_we <= pwdata_in[C_WR];
      bus.reg_addr <= dmahp_reg_addr(base, pwdata_in[2:0]);
      bus.reg_wdata <= wdata;
      // RULE_18: never set the reserved outbound bit
      if (pwdata_in[2:0] == IX_OCSR) begin
        bus.reg_wdata[B_SIG] <= 1'b0;
      end
    end else if (busy) begin
      if (bus.reg_ack) begin
        busy <= 1'b0;
        bus.reg_sel <= 1'b0;
        if (!cmd_we) begin
          rdata <= bus.reg_rdata;
        end
      end else if (tmo_cnt == REG_TMO) begin
        // No device at that address: give up rather than hang
        busy <= 1'b0;
        tmo <= 1'b1;
        bus.reg_sel <= 1'b0;
      end else begin
        tmo_cnt <= tmo_cnt + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Host memory answering device DMA
  // ------------------------------------------------------------
  assign serve = bus.mem_req & ~bus.mem_ack & ~bus.mem_nmr;
  assign d_hit = bus.mem_addr < MEM_LIMIT;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bus.mem_ack <= 1'b0;
      bus.mem_nmr <= 1'b0;
    end else begin
      bus.mem_ack <= serve & d_hit;
      // RULE_14: unanswered address reported
      bus.mem_nmr <= serve & ~d_hit;
    end
  end

  dmahp_mem u_mem (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .a_we_in(commit & m_hit),
    .a_addr_in(paddr_in[MEM_IW+1:2]),
    .a_wdata_in(pwdata_in[15:0]),
    .a_rdata_out(m_rd),
    .b_en_in(serve & d_hit),
    .b_we_in(bus.mem_we),
    .b_addr_in(bus.mem_addr[MEM_IW:1]),
    .b_wdata_in(bus.mem_wdata),
    .b_rdata_out(bus.mem_rdata)
  );
endmodule // dmahp_host

/* dmahp_if.sv */
`timescale 1ns/1ps
interface dmahp_if;
  logic reg_sel;
  logic reg_we;
  logic [17:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_ack;
  logic mem_req;
  logic mem_we;
  logic [17:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic mem_ack;
  logic mem_nmr;
  logic [1:0] irq;
  logic [7:0] irq_vec;

  modport dev (
    input reg_sel, reg_we, reg_addr, reg_wdata, mem_rdata, mem_ack, mem_nmr,
    output reg_rdata, reg_ack, mem_req, mem_we, mem_addr, mem_wdata, irq, irq_vec
  );
  modport host (
    output reg_sel, reg_we, reg_addr, reg_wdata, mem_rdata, mem_ack, mem_nmr,
    input reg_rdata, reg_ack, mem_req, mem_we, mem_addr, mem_wdata, irq, irq_vec
  );
endinterface

/* dmahp_mem.sv */
`timescale 1ns/1ps
module dmahp_mem
  import dmahp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic a_we_in,
  input wire logic [MEM_IW-1:0] a_addr_in,
  input wire logic [15:0] a_wdata_in,
  output logic [15:0] a_rdata_out,
  input wire logic b_en_in,
  input wire logic b_we_in,
  input wire logic [MEM_IW-1:0] b_addr_in,
  input wire logic [15:0] b_wdata_in,
  output logic [15:0] b_rdata_out
);
  logic [15:0] mem [2**MEM_IW];

  // A DMA port write drops any software write in the same cycle, to any word; software should not race its own DMA
  always_ff @(posedge ref_clk_in) begin
    if (b_en_in && b_we_in) begin
      mem[b_addr_in] <= b_wdata_in;
    end else if (a_we_in) begin
      mem[a_addr_in] <= a_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      a_rdata_out <= 16'h0000;
      b_rdata_out <= 16'h0000;
    end else begin
      a_rdata_out <= mem[a_addr_in];
      if (b_en_in) begin
        b_rdata_out <= mem[b_addr_in];
      end
    end
  end
endmodule // dmahp_mem

/* dmahp_monitor.sv */
`timescale 1ns/1ps
module dmahp_monitor
  import dmahp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic reg_sel,
  input wire logic [17:0] reg_addr,
  input wire logic reg_ack,
  input wire logic mem_req,
  input wire logic [17:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_nmr,
  input wire logic [1:0] irq,
  input wire logic [7:0] irq_vec
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Only the factory base is watched; a moved base just never answers here
  logic hit;
  assign hit = !reg_addr[0] && reg_addr >= CSR_BASE && reg_addr <= CSR_BASE + 18'h0000E;

  chk_ack_pulse: assert property (reg_ack |=> !reg_ack)
    else $error("register ack longer than one cycle");
  chk_ack_decoded: assert property (reg_ack |-> $past(reg_sel && hit))
    else $error("register ack without a decoded select");
  chk_sel_answer: assert property (reg_sel && !reg_ack && hit |=> reg_ack)
    else $error("decoded register access not answered");
  chk_nmr_far: assert property (mem_req && !mem_ack && !mem_nmr && mem_addr >= MEM_LIMIT |=> mem_nmr)
    else $error("absent memory not reported");
  chk_mem_answer: assert property (mem_req && !mem_ack && !mem_nmr |=> mem_ack ^ mem_nmr)
    else $error("memory cycle answered wrongly");
  chk_addr_hold: assert property (mem_req && !mem_ack && !mem_nmr |=> mem_req && $stable(mem_addr))
    else $error("memory request not held");
  chk_req_drop: assert property (mem_ack || mem_nmr |=> !mem_req)
    else $error("memory request kept after answer");
  chk_addr_even: assert property (mem_req |-> !mem_addr[0])
    else $error("odd DMA word address");
  chk_irq_vector: assert property (irq != 2'b00 |-> irq_vec == (irq[0] ? VEC_IN : VEC_OUT))
    else $error("interrupt vector wrong");
endmodule // dmahp_monitor

/* dmahp_pkg.sv */
package dmahp_pkg;

  // ------------------------------------------------------------
  // Device register block: bus placement, word index, bit fields
  // ------------------------------------------------------------
  localparam logic [17:0] CSR_BASE = 18'h3FC80;
  localparam logic [7:0] VEC_IN = 8'h60;
  localparam logic [7:0] VEC_OUT = 8'h64;
  localparam logic [1:0] OF_CSR = 2'h0;
  localparam logic [1:0] OF_DATA = 2'h1;
  localparam logic [1:0] OF_PTR = 2'h2;
  localparam logic [1:0] OF_CNT = 2'h3;
  localparam logic [2:0] IX_ICSR = {1'b0, OF_CSR};
  localparam logic [2:0] IX_IDR = {1'b0, OF_DATA};
  localparam logic [2:0] IX_IAR = {1'b0, OF_PTR};
  localparam logic [2:0] IX_ICNT = {1'b0, OF_CNT};
  localparam logic [2:0] IX_OCSR = {1'b1, OF_CSR};
  localparam logic [2:0] IX_ODR = {1'b1, OF_DATA};
  localparam logic [2:0] IX_OAR = {1'b1, OF_PTR};
  localparam logic [2:0] IX_OCNT = {1'b1, OF_CNT};
  localparam int B_GO = 0;
  localparam int B_CLR = 1;
  localparam int B_SIG = 2;
  localparam int B_FRST = 3;
  localparam int B_EXT = 4;
  localparam int B_IRQE = 6;
  localparam int B_RDY = 7;
  localparam int B_ST = 10;
  localparam int B_NMR = 14;
  localparam logic [15:0] CSR_RESET = 16'h0080;
  localparam logic [15:0] PTR_STEP = 16'h0002;
  localparam logic [15:0] CNT_STEP = 16'h0001;

  // ------------------------------------------------------------
  // Host controller APB map and host memory
  // ------------------------------------------------------------
  localparam logic [11:0] A_CMD = 12'h000;
  localparam logic [11:0] A_WDATA = 12'h004;
  localparam logic [11:0] A_RDATA = 12'h008;
  localparam logic [11:0] A_STAT = 12'h00C;
  localparam logic [11:0] A_BASE = 12'h010;
  localparam logic [11:0] A_MEM = 12'h400;
  localparam int C_WR = 8;
  localparam int C_GO = 31;
  localparam int MEM_IW = 6;
  localparam logic [17:0] MEM_LIMIT = 18'h00080;
  localparam logic [3:0] REG_TMO = 4'hF;

  typedef enum logic {MB_IDLE, MB_WAIT} dmahp_mb_t;

  function automatic logic [17:0] dmahp_reg_addr(input logic [17:0] base,
                                                 input logic [2:0] idx);
    return base + {14'h0000, idx, 1'b0};
  endfunction

endpackage

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top
  import dmahp_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} dmahp_exp_t;
  logic ref_clk_in = 1'b0, rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic fe_rx_req = 1'b0, fe_rx_valid = 1'b0, fe_tx_req = 1'b0, fe_tx_ready = 1'b0;
  logic halted = 1'b0, fe_rx_ready, fe_tx_valid, fe_restart;
  logic [15:0] fe_rx_data = 16'h0000, fe_tx_data, t;
  logic [15:0] w [3];
  logic [3:0] fe_status = 4'h0, st, host_status;
  dmahp_exp_t rq[$], e;
  logic [15:0] txq[$];
  int bad_count = 0, n_checks = 0, cycles = 0, restarts = 0, seed = 30;

  dmahp_if bus ();
  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) fe_tx_ready <= 1'($random(seed));

  dmahp_device i_dmahp_device (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus(bus),
    .fe_rx_req_in(fe_rx_req), .fe_rx_valid_in(fe_rx_valid), .fe_rx_data_in(fe_rx_data),
    .fe_rx_ready_out(fe_rx_ready), .fe_tx_req_in(fe_tx_req), .fe_tx_valid_out(fe_tx_valid),
    .fe_tx_data_out(fe_tx_data), .fe_tx_ready_in(fe_tx_ready),
    .frontend_cpu_halted_in(halted), .frontend_status_in(fe_status),
    .host_status_out(host_status), .frontend_cpu_restart_out(fe_restart));
  dmahp_host i_dmahp_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus(bus),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
  dmahp_monitor i_dmahp_monitor (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_sel(bus.reg_sel), .reg_addr(bus.reg_addr), .reg_ack(bus.reg_ack),
    .mem_req(bus.mem_req), .mem_addr(bus.mem_addr), .mem_ack(bus.mem_ack),
    .mem_nmr(bus.mem_nmr), .irq(bus.irq), .irq_vec(bus.irq_vec));

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  // Falling edge: registered outputs have settled, no race with the design
  always @(negedge ref_clk_in) begin
    if (psel && penable && pready && !pwrite && rq.size() > 0) begin
      e = rq.pop_front();
      if (e.m != 32'h0 || e.e) begin
        `CHK(prdata & e.m, e.d)
        `CHK(pslverr, e.e)
      end
    end
    if (fe_tx_valid && fe_tx_ready && txq.size() > 0) begin
      t = txq.pop_front();
      `CHK(fe_tx_data, t)
    end
    if (fe_restart) restarts++;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  // A read notes its expectation first; mask zero with no expected error means only consume it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'h0, input logic er = 1'b0);
    if (!wr) rq.push_back('{d, m, er});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    // Hold until pready is seen at a rising edge; only the bench timeout ends this
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic dev(input logic wr, input logic [2:0] ix, input logic [15:0] d);
    int n;
    n = 0;
    if (wr) apb(1'b1, A_WDATA, {16'h0000, d});
    apb(1'b1, A_CMD, {1'b1, 22'h000000, wr, 5'h00, ix});
    do begin apb(1'b0, A_STAT, 32'h0); n++; end while (r[0] !== 1'b0 && n < 40);
  endtask

  task automatic dchk(input logic [2:0] ix, input logic [15:0] d, input logic [15:0] m);
    dev(1'b0, ix, 16'h0000);
    apb(1'b0, A_RDATA, {16'h0000, d}, {16'h0000, m});
  endtask

  task automatic fe_send(input logic [15:0] v);
    int n;
    n = 0;
    fe_rx_valid <= 1'b1;
    fe_rx_data <= v;
    do begin @(negedge ref_clk_in); n++; end while (fe_rx_ready !== 1'b1 && n < 200);
    @(posedge ref_clk_in);
    fe_rx_valid <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic wait_irq(input int b);
    int n;
    n = 0;
    do begin @(negedge ref_clk_in); n++; end while (bus.irq[b] !== 1'b1 && n < 500);
    `CHK(bus.irq[b], 1'b1)
    @(posedge ref_clk_in);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    st = 4'($random(seed));
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    fe_status <= st;
    halted <= 1'b1;
    @(posedge ref_clk_in);
    dchk(IX_ICSR, {2'b00, st, 10'h280}, 16'hFFFF);
    dchk(IX_OCSR, 16'h0080, 16'hFFFF);
    dchk(IX_ICNT, 16'h0000, 16'hFFFF);
    apb(1'b0, 12'h200, 32'h0, 32'h0, 1'b1);
    apb(1'b1, A_BASE, 32'h0003FD00);
    dev(1'b0, IX_ICSR, 16'h0000);
    apb(1'b0, A_STAT, 32'h2, 32'h2);
    apb(1'b1, A_BASE, {14'h0000, CSR_BASE});
    $display("test reset done");
    halted <= 1'b0;
    dev(1'b1, IX_IAR, 16'h0010);
    dev(1'b1, IX_ICNT, 16'hFFFD);
    dev(1'b1, IX_ICSR, 16'h0041);
    repeat (20) @(posedge ref_clk_in);
    `CHK(bus.mem_req, 1'b0)
    dchk(IX_ICSR, {2'b00, st, 10'h040}, 16'hFFFF);
    fe_rx_req <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      w[i] = 16'($random(seed));
      fe_send(w[i]);
    end
    wait_irq(0);
    fe_rx_req <= 1'b0;
    dchk(IX_ICSR, {2'b00, st, 10'h0C4}, 16'hFFFF);
    dchk(IX_ICSR, {2'b00, st, 10'h0C0}, 16'hFFFF);
    `CHK(bus.irq[0], 1'b0)
    for (int i = 0; i < 3; i++) apb(1'b0, A_MEM + 12'(32 + 4 * i), {16'h0000, w[i]}, 32'hFFFF);
    dchk(IX_IAR, 16'h0016, 16'hFFFF);
    $display("test inbound done");
    for (int i = 0; i < 2; i++) begin
      w[i] = 16'($random(seed));
      apb(1'b1, A_MEM + 12'(80 + 4 * i), {16'h0000, w[i]});
      txq.push_back(w[i]);
    end
    dev(1'b1, IX_OAR, 16'h0028);
    dev(1'b1, IX_OCNT, 16'hFFFE);
    dev(1'b1, IX_OCSR, {2'b00, ~st, 10'h040});
    `CHK(host_status, ~st)
    dev(1'b1, IX_OCSR, {2'b00, ~st, 10'h041});
    dchk(IX_OCSR, {2'b00, ~st, 10'h000}, 16'hFC80);
    fe_tx_req <= 1'b1;
    wait_irq(1);
    fe_tx_req <= 1'b0;
    `CHK(txq.size(), 0)
    dchk(IX_OCSR, {2'b00, ~st, 10'h0C0}, 16'hFFFF);
    $display("test outbound done");
    dev(1'b1, IX_IAR, 16'h0000);
    dev(1'b1, IX_ICNT, 16'hFFFF);
    dev(1'b1, IX_ICSR, 16'h0011);
    fe_rx_req <= 1'b1;
    w[0] = 16'($random(seed));
    fe_send(w[0]);
    dchk(IX_ICSR, {2'b11, st, 10'h090}, 16'hFFFB);
    dchk(IX_IDR, w[0], 16'hFFFF);
    fe_rx_req <= 1'b0;
    dev(1'b1, IX_ICSR, 16'h0000);
    dchk(IX_ICSR, {2'b00, st, 10'h080}, 16'hFFFB);
    $display("test error done");
    dev(1'b1, IX_ICSR, 16'h0041);
    dev(1'b1, IX_ICSR, 16'h0080);
    dchk(IX_ICSR, {2'b00, st, 10'h0C0}, 16'hFFFB);
    dev(1'b1, IX_ICSR, 16'h0001);
    dev(1'b1, IX_ICSR, 16'h0002);
    dchk(IX_ICSR, {2'b00, st, 10'h080}, 16'hFFFF);
    dev(1'b1, IX_OCSR, 16'h0008);
    `CHK(restarts, 1)
    dchk(IX_OCSR, 16'h0080, 16'hFFFF);
    $display("test control done");
    summarize();
  end
endmodule // tb_top
